// >>> design/mag_map.svh
// constants of the address-generation block
`ifndef MAG_MAP_SVH
`define MAG_MAP_SVH
`define MAG_PC_ZERO       14'h0000
`define MAG_PC_STEP       14'h0001
`define MAG_PC_STEP2      14'h0002
`define MAG_INPAGE_TAG    2'h3
`define MAG_ZPAGE_TAG     4'h8
`define MAG_OP_LJUMP      6'h28
`define MAG_OP_LBRANCH    6'h29
`define MAG_OP_LSUB       6'h2A
`define MAG_OP_TJUMP      6'h2B
`define MAG_OP_TFETCH     6'h2C
`define MAG_OP_RDIRECT    6'h2D
`define MAG_OP_SCR_LOAD   6'h2E
`define MAG_OP_SCR_SWAP   6'h2F
`define MAG_OP_RINDIRECT  6'h24
`define MAG_SCRATCH_BASE  10'h040
`define MAG_TBL_ACC_BIT   8
`define MAG_TBL_PORT_BIT  9
`define MAG_TBL_TOP       2'h0
`endif

// >>> design/mag_pkg.sv
// types of the address-generation block
package mag_pkg;
   typedef enum logic [1:0] {
      MAG_S_FETCH = 2'b00,
      MAG_S_DEC   = 2'b01,
      MAG_S_OPND  = 2'b10,
      MAG_S_TBL   = 2'b11
   } mag_state_t;
   typedef enum logic [1:0] {
      MAG_RAM_INDIRECT = 2'b00,
      MAG_RAM_DIRECT   = 2'b01,
      MAG_RAM_SCRATCH  = 2'b10,
      MAG_RAM_SWAP     = 2'b11
   } mag_ram_mode_t;
   typedef struct packed {
      mag_ram_mode_t mode;
      logic [9:0]    addr;
   } mag_ram_req_t;
endpackage

// >>> design/mag_addr_gen.sv
// address generation and table fetch logic of the 4-bit core
`timescale 1ns/1ns
`include "mag_map.svh"
// What this block does
// - instruction words are ten bits wide
// - indirect RAM address is bank,row,column concatenated
// - direct RAM: two words, second is address
// - sixteen scratch registers reached by two ops
// - long ops replace all fourteen PC bits
// - sixty-four pages of 256 words each
// - in-page jump replaces low eight PC bits
// - jump at page end lands next page
// - zero-page call: six bits, upper zero
// - table jump from imm4, acc, extension
// - table fetch bit 8 writes accumulator pair
// - table fetch bit 9 writes port registers
// - both bits set update both targets
// - table fetch only advances PC normally
module mag_addr_gen #(
   parameter int PC_W = 14
) (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 ce,
   input  wire logic [9:0]           rom_data,
   input  wire logic [3:0]           acc_in,
   input  wire logic [3:0]           acc_ext_in,
   input  wire logic [1:0]           bank_sel,
   input  wire logic [3:0]           row_ptr,
   input  wire logic [3:0]           col_ptr,
   output logic [PC_W-1:0]           rom_addr_q,
   output logic [PC_W-1:0]           pc_q,
   output logic                      ram_req_q,
   output mag_pkg::mag_ram_req_t     ram_q,
   output logic                      acc_wr_q,
   output logic [3:0]                acc_q,
   output logic [3:0]                acc_ext_q,
   output logic                      port_wr_q,
   output logic [3:0]                port_group_one_out_q,
   output logic [3:0]                port_group_two_out_q
);
   // ***********************************
   // decode
   // ***********************************
   mag_pkg::mag_state_t   state_q;
   logic [5:0]            op_q;
   logic [5:0]            op6;
   logic [PC_W-1:0]       pc_inc;
   logic [PC_W-1:0]       tbl_addr;
   logic [3:0]            pc_hi_q;

   assign op6      = rom_data[9:4];
   assign pc_inc   = pc_q + `MAG_PC_STEP;
   assign tbl_addr = {`MAG_TBL_TOP, rom_data[3:0], acc_ext_in, acc_in};

   // ***********************************
   // sequencer
   // ***********************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= mag_pkg::MAG_S_FETCH;
         op_q    <= 6'h00;
      end else if (ce) begin
         case (state_q)
            mag_pkg::MAG_S_FETCH: state_q <= mag_pkg::MAG_S_DEC;
            mag_pkg::MAG_S_DEC: begin
               op_q <= op6;
               if (op6 == `MAG_OP_LJUMP || op6 == `MAG_OP_LBRANCH || op6 == `MAG_OP_LSUB ||
                   op6 == `MAG_OP_RDIRECT) begin
                  state_q <= mag_pkg::MAG_S_OPND;
               end else if (op6 == `MAG_OP_TFETCH) begin
                  state_q <= mag_pkg::MAG_S_TBL;
               end else begin
                  state_q <= mag_pkg::MAG_S_FETCH;
               end
            end
            mag_pkg::MAG_S_OPND: state_q <= mag_pkg::MAG_S_FETCH;
            mag_pkg::MAG_S_TBL:  state_q <= mag_pkg::MAG_S_FETCH;
            default:             state_q <= mag_pkg::MAG_S_FETCH;
         endcase
      end
   end

   // ***********************************
   // program counter
   // ***********************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pc_q <= `MAG_PC_ZERO;
      end else if (ce) begin
         if (state_q == mag_pkg::MAG_S_DEC) begin
            if (rom_data[9:8] == `MAG_INPAGE_TAG) begin
               pc_q <= {pc_inc[PC_W-1:8], rom_data[7:0]};
            end else if (rom_data[9:6] == `MAG_ZPAGE_TAG) begin
               pc_q <= {{(PC_W-6){1'b0}}, rom_data[5:0]};
            end else if (op6 == `MAG_OP_TJUMP) begin
               pc_q <= tbl_addr;
            end else if (op6 == `MAG_OP_LJUMP || op6 == `MAG_OP_LBRANCH || op6 == `MAG_OP_LSUB ||
                         op6 == `MAG_OP_RDIRECT) begin
               pc_q <= pc_q;
            end else begin
               pc_q <= pc_inc;
            end
         end else if (state_q == mag_pkg::MAG_S_OPND) begin
            if (op_q == `MAG_OP_RDIRECT) begin
               pc_q <= pc_q + `MAG_PC_STEP2;
            end else begin
               pc_q <= {pc_hi_q, rom_data};
            end
         end
      end
   end

   // high four target bits held from the first word
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pc_hi_q <= 4'h0;
      end else if (ce && state_q == mag_pkg::MAG_S_DEC) begin
         pc_hi_q <= rom_data[3:0];
      end
   end

   // ***********************************
   // ROM address
   // ***********************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rom_addr_q <= `MAG_PC_ZERO;
      end else if (ce) begin
         if (state_q == mag_pkg::MAG_S_FETCH) begin
            rom_addr_q <= pc_q;
         end else if (state_q == mag_pkg::MAG_S_DEC && op6 == `MAG_OP_TFETCH) begin
            rom_addr_q <= tbl_addr;
         end else if (state_q == mag_pkg::MAG_S_DEC) begin
            rom_addr_q <= pc_inc;
         end
      end
   end

   // ***********************************
   // RAM address
   // ***********************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ram_req_q <= 1'b0;
         ram_q     <= '{mode: mag_pkg::MAG_RAM_INDIRECT, addr: 10'h000};
      end else if (ce) begin
         ram_req_q <= 1'b0;
         if (state_q == mag_pkg::MAG_S_DEC && op6 == `MAG_OP_RINDIRECT) begin
            ram_req_q <= 1'b1;
            ram_q     <= '{mode: mag_pkg::MAG_RAM_INDIRECT, addr: {bank_sel, row_ptr, col_ptr}};
         end else if (state_q == mag_pkg::MAG_S_DEC &&
                      (op6 == `MAG_OP_SCR_LOAD || op6 == `MAG_OP_SCR_SWAP)) begin
            ram_req_q      <= 1'b1;
            ram_q.mode     <= (op6 == `MAG_OP_SCR_LOAD) ? mag_pkg::MAG_RAM_SCRATCH : mag_pkg::MAG_RAM_SWAP;
            ram_q.addr     <= `MAG_SCRATCH_BASE | {6'h00, rom_data[3:0]};
         end else if (state_q == mag_pkg::MAG_S_OPND && op_q == `MAG_OP_RDIRECT) begin
            ram_req_q <= 1'b1;
            ram_q     <= '{mode: mag_pkg::MAG_RAM_DIRECT, addr: rom_data};
         end
      end
   end

   // ***********************************
   // table fetch writes
   // ***********************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_wr_q             <= 1'b0;
         port_wr_q            <= 1'b0;
         acc_q                <= 4'h0;
         acc_ext_q            <= 4'h0;
         port_group_one_out_q <= 4'h0;
         port_group_two_out_q <= 4'h0;
      end else if (ce) begin
         acc_wr_q  <= 1'b0;
         port_wr_q <= 1'b0;
         if (state_q == mag_pkg::MAG_S_TBL) begin
            if (rom_data[`MAG_TBL_ACC_BIT]) begin
               acc_wr_q  <= 1'b1;
               acc_q     <= rom_data[3:0];
               acc_ext_q <= rom_data[7:4];
            end
            if (rom_data[`MAG_TBL_PORT_BIT]) begin
               port_wr_q            <= 1'b1;
               port_group_one_out_q <= rom_data[3:0];
               port_group_two_out_q <= rom_data[7:4];
            end
         end
      end
   end

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence dec_s;
      state_q == mag_pkg::MAG_S_DEC && ce;
   endsequence

   pc_reset_a: assert property (disable iff (1'b0) $rose(rst_n) |-> pc_q == `MAG_PC_ZERO)
      else $error("pc not zero after reset");
   inpage_jump_a: assert property (dec_s ##0 rom_data[9:8] == `MAG_INPAGE_TAG |=>
      pc_q == {$past(pc_inc[PC_W-1:8]), $past(rom_data[7:0])})
      else $error("in-page jump target wrong");
   zero_call_a: assert property (dec_s ##0 rom_data[9:6] == `MAG_ZPAGE_TAG |=>
      pc_q == {{(PC_W-6){1'b0}}, $past(rom_data[5:0])})
      else $error("zero-page call target wrong");
   long_target_a: assert property (state_q == mag_pkg::MAG_S_OPND && ce && $past(ce) && op_q != `MAG_OP_RDIRECT |=>
      pc_q == {$past(rom_data[3:0], 2), $past(rom_data)})
      else $error("long target wrong");
   direct_ram_a: assert property (state_q == mag_pkg::MAG_S_OPND && ce && op_q == `MAG_OP_RDIRECT |=>
      ram_req_q && ram_q.addr == $past(rom_data) && pc_q == $past(pc_q) + `MAG_PC_STEP2)
      else $error("direct ram access wrong");
   indirect_ram_a: assert property (dec_s ##0 op6 == `MAG_OP_RINDIRECT |=>
      ram_req_q && ram_q.addr == {$past(bank_sel), $past(row_ptr), $past(col_ptr)})
      else $error("indirect address wrong");
   scratch_ram_a: assert property (ram_req_q && ram_q.mode inside {mag_pkg::MAG_RAM_SCRATCH, mag_pkg::MAG_RAM_SWAP}
      |-> ram_q.addr[9:4] == `MAG_SCRATCH_BASE >> 4)
      else $error("scratch address out of range");
   tbl_write_a: assert property (state_q == mag_pkg::MAG_S_TBL && ce |=>
      acc_wr_q == $past(rom_data[`MAG_TBL_ACC_BIT]) && port_wr_q == $past(rom_data[`MAG_TBL_PORT_BIT]))
      else $error("table fetch write enables wrong");
   tbl_pc_a: assert property (dec_s ##0 op6 == `MAG_OP_TFETCH |=> pc_q == $past(pc_inc) ##1 pc_q == $past(pc_q))
      else $error("table fetch disturbed pc");
endmodule // mag_addr_gen

// >>> sim/mag_rom_model.sv
// program ROM model answering the fetch address
`timescale 1ns/1ns
module mag_rom_model (
   input  wire logic [13:0] rom_addr,
   output logic      [9:0]  rom_data
);
   // 64 pages of 256 ten-bit words
   logic [9:0] mem [16384] = '{default: 10'h000};
   assign rom_data = mem[rom_addr];
endmodule // mag_rom_model

// >>> sim/tb_top.sv
// self-checking bench of the address-generation block
`timescale 1ns/1ns
`include "mag_map.svh"
module tb_top;
   // ****************
   // signals
   // ****************
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  ce = 1'b1;
   logic [3:0]            acc_in = 4'h0;
   logic [3:0]            acc_ext_in = 4'h0;
   logic [1:0]            bank_sel = 2'h0;
   logic [3:0]            row_ptr = 4'h0;
   logic [3:0]            col_ptr = 4'h0;
   logic [9:0]            rom_data;
   logic [13:0]           rom_addr_q;
   logic [13:0]           pc_q;
   logic                  ram_req_q;
   mag_pkg::mag_ram_req_t ram_q;
   logic                  acc_wr_q;
   logic [3:0]            acc_q;
   logic [3:0]            acc_ext_q;
   logic                  port_wr_q;
   logic [3:0]            port_one_q;
   logic [3:0]            port_two_q;
   int                    miscompares = 0;
   int                    checks_done = 0;
   int                    cycles = 0;
   mag_pkg::mag_ram_req_t ram_log[$];
   logic [7:0]            acc_log[$];
   logic [7:0]            port_log[$];
   always #2 clk = ~clk;
   mag_addr_gen #(.PC_W(14)) i_mag_addr_gen (.clk(clk), .rst_n(rst_n), .ce(ce), .rom_data(rom_data),
      .acc_in(acc_in), .acc_ext_in(acc_ext_in), .bank_sel(bank_sel), .row_ptr(row_ptr), .col_ptr(col_ptr),
      .rom_addr_q(rom_addr_q), .pc_q(pc_q), .ram_req_q(ram_req_q), .ram_q(ram_q), .acc_wr_q(acc_wr_q),
      .acc_q(acc_q), .acc_ext_q(acc_ext_q), .port_wr_q(port_wr_q), .port_group_one_out_q(port_one_q),
      .port_group_two_out_q(port_two_q));
   mag_rom_model i_mag_rom_model (.rom_addr(rom_addr_q), .rom_data(rom_data));
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         miscompares++;
         complete_run();
      end
      if (ram_req_q === 1'b1) ram_log.push_back(ram_q);
      if (acc_wr_q === 1'b1) acc_log.push_back({acc_ext_q, acc_q});
      if (port_wr_q === 1'b1) port_log.push_back({port_two_q, port_one_q});
   end
   // ****************
   // tasks
   // ****************
   task automatic complete_run();
      if (miscompares == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk_pc(input logic [13:0] exp);
      checks_done++;
      if (pc_q !== exp) begin
         miscompares++;
         $display("MISMATCH %0t pc %h exp %h", $time, pc_q, exp);
      end
   endtask
   task automatic chk_rom(input logic [13:0] exp);
      checks_done++;
      if (rom_addr_q !== exp) begin
         miscompares++;
         $display("MISMATCH %0t rom address %h exp %h", $time, rom_addr_q, exp);
      end
   endtask
   task automatic chk_ram(input mag_pkg::mag_ram_req_t got, input mag_pkg::mag_ram_req_t exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t ram %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_dat(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t data %h exp %h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [13:0] a, input logic [9:0] w);
      i_mag_rom_model.mem[a] = w;
   endtask
   task automatic step(input int n, input logic [13:0] exp);
      repeat (n) @(posedge clk);
      #1;
      chk_pc(exp);
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      chk_pc(14'h0000);
      ram_log.delete();
      acc_log.delete();
      port_log.delete();
   endtask
   task automatic sc_long();
      logic [5:0] ops [3] = '{`MAG_OP_LJUMP, `MAG_OP_LBRANCH, `MAG_OP_LSUB};
      foreach (ops[i]) begin
         put(0, {ops[i], 4'hA});
         put(1, 10'h3C5);
         do_reset();
         step(3, 14'h2BC5);
      end
   endtask
   task automatic sc_page();
      put(0, {`MAG_OP_LJUMP, 4'h0});
      put(1, 10'h1FF);
      put(14'h01FF, {`MAG_INPAGE_TAG, 8'h12});
      put(14'h0212, {`MAG_ZPAGE_TAG, 6'h2D});
      put(14'h002D, {`MAG_OP_TJUMP, 4'h5});
      put(14'h05C3, {`MAG_INPAGE_TAG, 8'h01});
      acc_in = 4'h3;
      acc_ext_in = 4'hC;
      do_reset();
      step(3, 14'h01FF);
      step(2, 14'h0212);
      step(2, 14'h002D);
      step(2, 14'h05C3);
      step(2, 14'h0501);
   endtask
   task automatic sc_ram();
      put(0, {`MAG_OP_RINDIRECT, 4'h0});
      put(1, {`MAG_OP_RDIRECT, 4'h0});
      put(2, 10'h3A7);
      put(3, {`MAG_OP_SCR_LOAD, 4'hF});
      put(4, {`MAG_OP_SCR_SWAP, 4'h0});
      bank_sel = 2'h2;
      row_ptr = 4'h9;
      col_ptr = 4'h6;
      do_reset();
      step(2, 14'h0001);
      step(3, 14'h0003);
      step(2, 14'h0004);
      step(2, 14'h0005);
      step(2, 14'h0006);
      chk_ram(ram_log.pop_front(), '{mag_pkg::MAG_RAM_INDIRECT, 10'h296});
      chk_ram(ram_log.pop_front(), '{mag_pkg::MAG_RAM_DIRECT, 10'h3A7});
      chk_ram(ram_log.pop_front(), '{mag_pkg::MAG_RAM_SCRATCH, 10'h04F});
      chk_ram(ram_log.pop_front(), '{mag_pkg::MAG_RAM_SWAP, 10'h040});
   endtask
   task automatic sc_table();
      put(0, {`MAG_OP_TFETCH, 4'h2});
      put(14'h0213, {2'h1, 8'hA5});
      put(1, {`MAG_OP_TFETCH, 4'h3});
      put(14'h0313, {2'h2, 8'h6C});
      put(2, {`MAG_OP_TFETCH, 4'h4});
      put(14'h0413, {2'h3, 8'h9F});
      put(3, {`MAG_OP_TFETCH, 4'h5});
      put(14'h0513, {2'h0, 8'hFF});
      put(4, 10'h000);
      acc_in = 4'h3;
      acc_ext_in = 4'h1;
      do_reset();
      step(3, 14'h0001);
      chk_rom(14'h0213);
      step(3, 14'h0002);
      step(3, 14'h0003);
      step(3, 14'h0004);
      step(2, 14'h0005);
      chk_dat(acc_log.pop_front(), 8'hA5);
      chk_dat(acc_log.pop_front(), 8'h9F);
      chk_dat(8'(acc_log.size()), 8'h00);
      chk_dat(port_log.pop_front(), 8'h6C);
      chk_dat(port_log.pop_front(), 8'h9F);
      chk_dat({port_two_q, port_one_q}, 8'h9F);
      ce = 1'b0;
      step(4, 14'h0005);
      ce = 1'b1;
   endtask
   initial begin
      sc_long();
      sc_page();
      sc_ram();
      sc_table();
      complete_run();
   end
endmodule // tb_top
